// *** pkg/sdc_pkg.sv ***
package sdc_pkg;

    // Register byte offsets on the AXI4-Lite slave
    localparam logic [7:0] OFF_DECIMATION = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PRIM_REF = 8'h0C;
    localparam logic [7:0] OFF_AUX_CTRL = 8'h10;
    localparam logic [7:0] OFF_CURRENT_SOURCE_CONTROL_REG = 8'h14;
    localparam logic [7:0] OFF_PRIM_IN = 8'h18;
    localparam logic [7:0] OFF_CAL_CMD = 8'h1C;
    localparam logic [7:0] OFF_RESULT = 8'h20;

    // Field positions
    localparam int MODE_CHOP_DIS_BIT = 3;
    localparam int MODE_NOTCH60_BIT = 6;
    localparam int CURRENT_SOURCE_CONTROL_REG_BURNOUT_BIT = 6;
    localparam int AUX_REF_BIT = 6;
    localparam int PREF_SEL_LSB = 6;
    localparam int PIN_BUF_LSB = 6;
    localparam int PIN_CHAN_LSB = 0;
    localparam int ST_RDY_BIT = 0;
    localparam int ST_REF_MISSING_BIT = 1;
    localparam int ST_PRIM_ERR_BIT = 2;
    localparam int ST_AUX_ERR_BIT = 3;
    localparam int ST_SETTLING_BIT = 4;
    localparam int ST_NOTCH_BAD_BIT = 5;

    // Reset values and limits
    localparam logic [7:0] DECIM_RESET = 8'h45;
    localparam logic [7:0] DECIM_MIN_NOCHOP = 8'h03;
    localparam logic [7:0] DECIM_MIN_CHOP = 8'h0D;
    localparam logic [7:0] NOTCH_MIN_WORD = 8'h44;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [1:0] SETTLE_CONVERSIONS = 2'h3;
    localparam logic [23:0] CLAMP_VALUE = 24'hFFFFFF;

    // Timing: modulator runs at 32.768 kHz, system clock at 200 MHz
    localparam longint CLK_HZ = 200000000;
    localparam longint MOD_HZ = 32768;
    localparam int MOD_DIV_CYCLES = int'(CLK_HZ / MOD_HZ);
    // One decimation step = 8 modulator samples = 0.244 ms
    localparam int MOD_PER_STEP = 8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reference choice delivered to the analog section
    typedef enum logic [1:0] { SDC_REF_INTERNAL, SDC_REF_EXT1, SDC_REF_EXT2 } sdc_ref_t;

    typedef enum logic [1:0] { SDC_CAL_NONE, SDC_CAL_PRIMARY, SDC_CAL_AUX } sdc_cal_t;

    // Analog configuration outputs
    typedef struct packed {
        sdc_ref_t prim_ref;
        sdc_ref_t aux_ref;
        logic burnout_pair_a;
        logic burnout_pair_b;
        logic notch60_enable;
        logic chop_enable;
        logic [7:0] effective_decimation;
    } sdc_cfg_t;

endpackage

// *** rtl/sdc_ctrl.sv ***
module sdc_ctrl import sdc_pkg::*; (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // AXI4-Lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Analog section: reference detect and filter output
    input wire logic ref1_valid_pin,
    input wire logic filter_word_valid,
    input wire logic [23:0] filter_word,
    // Analog configuration and calibration register update
    output sdc_cfg_t cfg,
    output logic cal_write,
    output sdc_cal_t cal_target,
    output logic [23:0] cal_value
);

    logic [7:0] decimation_word;
    logic [7:0] converter_mode_reg;
    logic [7:0] primary_ref_control_reg;
    logic [7:0] aux_control_reg;
    logic [7:0] current_source_control_reg;
    logic [7:0] primary_input_control_reg;
    logic ref_sync1, ref_sync2;
    logic ref_missing_flag;
    logic primary_cal_error, aux_cal_error;
    logic data_ready;
    logic [1:0] settle_cnt;
    logic [23:0] result;
    logic [23:0] prev_word;
    logic have_prev;
    sdc_cal_t cal_active;
    logic cal_ref_lost;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire, rd_fire;
    logic status_read;
    logic chop_disabled;
    logic [7:0] eff_word;
    logic sync_step;

    // Swapping (chop) is off when mode bit 3 is set
    assign chop_disabled = converter_mode_reg[MODE_CHOP_DIS_BIT];

    // Clamp low words; the stored word itself is left as written
    always_comb begin
        eff_word = decimation_word;
        if (!chop_disabled && decimation_word < DECIM_MIN_CHOP) begin
            eff_word = DECIM_MIN_CHOP;
        end else if (chop_disabled && decimation_word < DECIM_MIN_NOCHOP) begin
            eff_word = DECIM_MIN_NOCHOP;
        end
    end

    // Configuration driven to the modulator and filter
    always_comb begin
        cfg.effective_decimation = eff_word;
        cfg.chop_enable = !chop_disabled;
        cfg.notch60_enable = converter_mode_reg[MODE_NOTCH60_BIT];
        case (primary_ref_control_reg[PREF_SEL_LSB +: 2])
            2'h1: cfg.prim_ref = SDC_REF_EXT1;
            2'h2: cfg.prim_ref = SDC_REF_EXT2;
            default: cfg.prim_ref = SDC_REF_INTERNAL;
        endcase
        // Auxiliary converter cannot reach the second pair
        cfg.aux_ref = aux_control_reg[AUX_REF_BIT] ? SDC_REF_EXT1 : SDC_REF_INTERNAL;
        // Burnout only on the two designated pairs and only when buffered
        cfg.burnout_pair_a = current_source_control_reg[CURRENT_SOURCE_CONTROL_REG_BURNOUT_BIT]
            && primary_input_control_reg[PIN_BUF_LSB] && primary_input_control_reg[PIN_CHAN_LSB +: 3] == 3'h2;
        cfg.burnout_pair_b = current_source_control_reg[CURRENT_SOURCE_CONTROL_REG_BURNOUT_BIT]
            && primary_input_control_reg[PIN_BUF_LSB + 1] && primary_input_control_reg[PIN_CHAN_LSB +: 3] == 3'h3;
    end

    // First reference pair detect, two-flop synchroniser; second pair is never looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Reset to the good level so no false loss follows reset
            ref_sync1 <= 1'b1;
            ref_sync2 <= 1'b1;
        end else if (clk_en) begin
            ref_sync1 <= ref1_valid_pin;
            ref_sync2 <= ref_sync1;
        end
    end

    // Missing-reference flag follows the synchronised detector level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_missing_flag <= 1'b0;
        end else if (clk_en) begin
            ref_missing_flag <= !ref_sync2;
        end
    end

    // AXI write channel capture; address and data taken in either order
    // Ready stays low while frozen, so nothing is taken that cannot be stored
    assign s_awready = clk_en && !aw_held && !s_bvalid;
    assign s_wready = clk_en && !w_held && !s_bvalid;
    assign wr_fire = aw_held && w_held && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_awvalid && s_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held <= 1'b1;
                w_data <= s_wdata;
                w_strb <= s_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_bvalid <= 1'b1;
                case (aw_addr)
                    OFF_DECIMATION, OFF_MODE, OFF_PRIM_REF, OFF_AUX_CTRL, OFF_CURRENT_SOURCE_CONTROL_REG, OFF_PRIM_IN, OFF_CAL_CMD:
                        s_bresp <= RESP_OKAY;
                    OFF_STATUS, OFF_RESULT: s_bresp <= RESP_OKAY; // Read-only, write ignored
                    default: s_bresp <= RESP_SLVERR;
                endcase
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Software-writable control registers, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            decimation_word <= DECIM_RESET;
            converter_mode_reg <= MODE_RESET;
            primary_ref_control_reg <= 8'h00;
            aux_control_reg <= 8'h00;
            current_source_control_reg <= 8'h00;
            primary_input_control_reg <= 8'h00;
        end else if (clk_en && wr_fire && w_strb[0]) begin
            case (aw_addr)
                OFF_DECIMATION: decimation_word <= w_data[7:0];
                OFF_MODE: converter_mode_reg <= w_data[7:0];
                OFF_PRIM_REF: primary_ref_control_reg <= w_data[7:0];
                OFF_AUX_CTRL: aux_control_reg <= w_data[7:0];
                OFF_CURRENT_SOURCE_CONTROL_REG: current_source_control_reg <= w_data[7:0];
                OFF_PRIM_IN: primary_input_control_reg <= w_data[7:0];
                default: ;
            endcase
        end
    end

    // A channel, mode or decimation write counts as a synchronized step
    assign sync_step = wr_fire && w_strb[0] && (aw_addr == OFF_PRIM_IN || aw_addr == OFF_MODE
        || aw_addr == OFF_DECIMATION);

    // Calibration sequencing: start via command register, finish on next filter word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cal_active <= SDC_CAL_NONE;
            cal_ref_lost <= 1'b0;
            cal_write <= 1'b0;
            cal_target <= SDC_CAL_NONE;
            cal_value <= 24'h000000;
        end else if (clk_en) begin
            cal_write <= 1'b0;
            if (cal_active == SDC_CAL_NONE) begin
                if (wr_fire && w_strb[0] && aw_addr == OFF_CAL_CMD && w_data[1:0] != 2'h0) begin
                    cal_active <= w_data[0] ? SDC_CAL_PRIMARY : SDC_CAL_AUX;
                    cal_ref_lost <= 1'b0;
                end
            end else begin
                // Loss at any point of the calibration is remembered
                if (ref_missing_flag) begin
                    cal_ref_lost <= 1'b1;
                end
                if (filter_word_valid) begin
                    cal_active <= SDC_CAL_NONE;
                    // Reference present throughout, so this result is usable
                    if (!cal_ref_lost && !ref_missing_flag) begin
                        cal_write <= 1'b1;
                        cal_target <= cal_active;
                        cal_value <= filter_word;
                    end
                end
            end
        end
    end

    // Conversion results: averaging with swapping, settle count without, clamp on missing ref
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= 24'h000000;
            prev_word <= 24'h000000;
            have_prev <= 1'b0;
            settle_cnt <= 2'h0;
            data_ready <= 1'b0;
        end else if (clk_en) begin
            if (sync_step) begin
                settle_cnt <= SETTLE_CONVERSIONS;
                have_prev <= 1'b0;
            end else if (filter_word_valid && cal_active == SDC_CAL_NONE) begin
                prev_word <= filter_word;
                have_prev <= 1'b1;
                if (chop_disabled && settle_cnt != 2'h0) begin
                    settle_cnt <= settle_cnt - 2'h1;
                end else if (!chop_disabled && !have_prev) begin
                    // Swapping needs a pair of filter words before the first average
                    settle_cnt <= 2'h0;
                end else begin
                    data_ready <= 1'b1;
                    if (ref_missing_flag) begin
                        result <= CLAMP_VALUE;
                    end else if (!chop_disabled) begin
                        result <= 24'((25'(filter_word) + 25'(prev_word)) >> 1);
                    end else begin
                        result <= filter_word;
                    end
                end
            end
            // Reading the result clears ready unless a filter word arrives outside calibration the same cycle
            if (rd_fire && s_araddr == OFF_RESULT && !(filter_word_valid && cal_active == SDC_CAL_NONE)) begin
                data_ready <= 1'b0;
            end
        end
    end

    // Calibration error bits: set wins over clear-on-status-read
    assign status_read = rd_fire && s_araddr == OFF_STATUS;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primary_cal_error <= 1'b0;
            aux_cal_error <= 1'b0;
        end else if (clk_en) begin
            if (status_read) begin
                primary_cal_error <= 1'b0;
                aux_cal_error <= 1'b0;
            end
            if (filter_word_valid && (cal_ref_lost || ref_missing_flag)) begin
                if (cal_active == SDC_CAL_PRIMARY) primary_cal_error <= 1'b1;
                if (cal_active == SDC_CAL_AUX) aux_cal_error <= 1'b1;
            end
        end
    end

    // AXI read channel: one outstanding read, answer one cycle after address
    assign s_arready = clk_en && !s_rvalid;
    assign rd_fire = s_arvalid && s_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (rd_fire) begin
                s_rvalid <= 1'b1;
                s_rresp <= RESP_OKAY;
                case (s_araddr)
                    OFF_DECIMATION: s_rdata <= {24'h000000, decimation_word};
                    OFF_MODE: s_rdata <= {24'h000000, converter_mode_reg};
                    OFF_STATUS: begin
                        s_rdata <= 32'h00000000;
                        s_rdata[ST_RDY_BIT] <= data_ready;
                        s_rdata[ST_REF_MISSING_BIT] <= ref_missing_flag;
                        s_rdata[ST_PRIM_ERR_BIT] <= primary_cal_error;
                        s_rdata[ST_AUX_ERR_BIT] <= aux_cal_error;
                        s_rdata[ST_SETTLING_BIT] <= settle_cnt != 2'h0;
                        // Notch with too small a word gives wrong results
                        s_rdata[ST_NOTCH_BAD_BIT] <= converter_mode_reg[MODE_NOTCH60_BIT]
                            && eff_word < NOTCH_MIN_WORD;
                    end
                    OFF_PRIM_REF: s_rdata <= {24'h000000, primary_ref_control_reg};
                    OFF_AUX_CTRL: s_rdata <= {24'h000000, aux_control_reg};
                    OFF_CURRENT_SOURCE_CONTROL_REG: s_rdata <= {24'h000000, current_source_control_reg};
                    OFF_PRIM_IN: s_rdata <= {24'h000000, primary_input_control_reg};
                    OFF_CAL_CMD: s_rdata <= {30'h00000000, cal_active};
                    OFF_RESULT: s_rdata <= {8'h00, result};
                    default: begin
                        s_rdata <= 32'h00000000;
                        s_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

endmodule // sdc_ctrl

// *** sim/sdc_ctrl_assertions.sv ***
module sdc_ctrl_assertions import sdc_pkg::*; (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic [31:0] s_rdata,
    input wire logic s_rvalid,
    input wire logic s_rready,
    // Analog side
    input wire logic ref1_valid_pin,
    input wire logic filter_word_valid,
    input wire sdc_cfg_t cfg,
    input wire logic cal_write
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Floors apply to the filter word only; the stored word stays as written
    chop_floor_a: assert property (cfg.chop_enable |-> cfg.effective_decimation >= DECIM_MIN_CHOP)
        else $error("effective word below chop floor");
    nochop_floor_a: assert property (!cfg.chop_enable |-> cfg.effective_decimation >= DECIM_MIN_NOCHOP)
        else $error("effective word below floor");
    reset_word_a: assert property (
        $rose(aresetn) |-> cfg.effective_decimation == DECIM_RESET && cfg.chop_enable)
        else $error("wrong word after reset");
    // The auxiliary converter has no path to the second pair
    aux_pair_a: assert property (cfg.aux_ref != SDC_REF_EXT2)
        else $error("aux converter on second pair");
    // Five low samples outlast the two-flop synchroniser and the flag register
    cal_block_a: assert property (!ref1_valid_pin [*5] |=> !cal_write)
        else $error("calibration written without reference");
    cal_pulse_a: assert property (cal_write |=> !cal_write)
        else $error("calibration update longer than one cycle");
    cal_cause_a: assert property (cal_write |-> $past(filter_word_valid))
        else $error("calibration update without filter word");
    // Bus answers
    // Both halves held after one edge, response registered on the next
    write_resp_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("no write response");
    read_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped");
endmodule // sdc_ctrl_assertions

// *** sim/sdc_ctrl_tb_top.sv ***
module sdc_ctrl_tb_top import sdc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    // Stimulus side
    logic aclk = 0;
    logic aresetn = 0;
    logic clk_en = 1;
    logic [7:0] s_awaddr = 0, s_araddr = 0;
    logic [31:0] s_wdata = 0;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic ref1_valid_pin = 1, filter_word_valid = 0;
    logic [23:0] filter_word = 0;
    // Observed side
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, cal_write;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    sdc_cfg_t cfg;
    sdc_cal_t cal_target;
    logic [23:0] cal_value;
    // Expectation queues and helpers
    logic [65:0] rq[$];
    logic [25:0] cq[$];
    logic [65:0] e;
    logic [25:0] c;
    logic [31:0] seed = 32'h1CC70AB9;
    logic [7:0] w, lo;
    logic [23:0] v;
    logic [1:0] r;
    int errors = 0, n_compared = 0;
    logic [7:0] wl [6] = '{8'h00, 8'h02, 8'h03, 8'h0C, 8'h0D, 8'hFF};
    sdc_ref_t pr [4] = '{SDC_REF_INTERNAL, SDC_REF_EXT1, SDC_REF_EXT2, SDC_REF_INTERNAL};

    sdc_ctrl sdc_ctrl_inst (.aclk, .aresetn, .clk_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb,
        .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .ref1_valid_pin, .filter_word_valid, .filter_word, .cfg, .cal_write,
        .cal_target, .cal_value);

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        n_compared++;
        if ((got & msk) !== (exp & msk)) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got & msk, exp & msk);
        end
    endtask

    // Configuration outputs are compared as bytes
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp({24'h0, got}, {24'h0, exp}, 32'hFF);
    endtask

    task automatic results();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tmo();
        errors++;
        $display("unexpected at %0t: bus wait ran out", $time);
        results();
    endtask

    // Address and data offered together; bready raised only after both are taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ad;
        logic wd;
        ad = 0;
        wd = 0;
        n = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1;
        s_wvalid <= 1;
        while (!(ad && wd) && n < 50) begin
            @(posedge aclk);
            n++;
            if (s_awready && !ad) s_awvalid <= 0;
            if (s_wready && !wd) s_wvalid <= 0;
            ad = ad | s_awready;
            wd = wd | s_wready;
        end
        s_bready <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_bvalid && n < 100);
        r = s_bresp;
        s_bready <= 0;
        if (n >= 100) tmo();
    endtask

    // Read; rready sometimes held back a cycle so the data must stand
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk,
        input logic [1:0] rsp = RESP_OKAY);
        int n;
        n = 0;
        rq.push_back({rsp, msk, exp});
        s_araddr <= a;
        s_arvalid <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_arready && n < 50);
        s_arvalid <= 0;
        if (rnd() & 32'h1) @(posedge aclk);
        s_rready <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_rvalid && n < 100);
        s_rready <= 0;
        if (n >= 100) tmo();
    endtask

    // One-cycle filter word pulse
    task automatic fw(input logic [23:0] d);
        filter_word <= d;
        filter_word_valid <= 1;
        @(posedge aclk);
        filter_word_valid <= 0;
        @(posedge aclk);
    endtask

    // Oldest expectation meets each read answer and each calibration update
    always @(posedge aclk) begin
        if (s_rvalid && s_rready) begin
            e = rq.size() > 0 ? rq.pop_front() : {~s_rresp, 32'hFFFFFFFF, ~s_rdata};
            cmp(s_rdata, e[31:0], e[63:32]);
            cmp({30'h0, s_rresp}, {30'h0, e[65:64]}, 32'h3);
        end
        if (cal_write) begin
            c = cq.size() > 0 ? cq.pop_front() : ~{cal_target, cal_value};
            cmp({6'h0, cal_target, cal_value}, {6'h0, c}, 32'h03FFFFFF);
        end
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(cfg.effective_decimation, DECIM_RESET);
        rd(OFF_DECIMATION, {24'h0, DECIM_RESET}, 32'hFF);
        rd(OFF_MODE, 32'h0, 32'hFF);
        // Word sweep with chop on, then off: corners first, then random words
        for (int m = 0; m < 2; m++) begin
            wr(OFF_MODE, m ? 32'h08 : 32'h00);
            chk({7'h0, cfg.chop_enable}, m ? 8'h00 : 8'h01);
            lo = m ? DECIM_MIN_NOCHOP : DECIM_MIN_CHOP;
            for (int i = 0; i < 10; i++) begin
                w = i < 6 ? wl[i] : 8'(rnd());
                wr(OFF_DECIMATION, {24'h0, w});
                rd(OFF_DECIMATION, {24'h0, w}, 32'hFF);
                chk(cfg.effective_decimation, w < lo ? lo : w);
            end
        end
        // Notch at and just below its lowest valid word
        for (int i = 0; i < 2; i++) begin
            wr(OFF_DECIMATION, i ? 32'h44 : 32'h43);
            wr(OFF_MODE, 32'h48);
            chk({7'h0, cfg.notch60_enable}, 8'h01);
            rd(OFF_STATUS, i ? 32'h0 : 32'h20, 32'h20);
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFF_PRIM_REF, 32'(i) << 6);
            wr(OFF_AUX_CTRL, 32'(i & 1) << 6);
            chk(8'(cfg.prim_ref), 8'(pr[i]));
            chk(8'(cfg.aux_ref), (i & 1) ? 8'(SDC_REF_EXT1) : 8'(SDC_REF_INTERNAL));
        end
        // Burnout needs its enable and buffering together
        wr(OFF_CURRENT_SOURCE_CONTROL_REG, 32'h40);
        wr(OFF_PRIM_IN, 32'h02);
        chk({7'h0, cfg.burnout_pair_a}, 8'h00);
        wr(OFF_PRIM_IN, 32'hC2);
        chk({6'h0, cfg.burnout_pair_a, cfg.burnout_pair_b}, 8'h02);
        wr(OFF_CURRENT_SOURCE_CONTROL_REG, 32'h00);
        chk({7'h0, cfg.burnout_pair_a}, 8'h00);
        // Chop off: three words withheld after a step, then raw words pass
        wr(OFF_MODE, 32'h08);
        repeat (3) fw(24'(rnd()));
        rd(OFF_RESULT, 32'h0, 32'hFFFFFF);
        v = 24'(rnd());
        fw(v);
        rd(OFF_RESULT, {8'h0, v}, 32'hFFFFFF);
        // Clock enable low: a filter word in the frozen window must not land
        clk_en <= 0;
        fw(24'(rnd()));
        clk_en <= 1;
        rd(OFF_RESULT, {8'h0, v}, 32'hFFFFFF);
        // Lost reference: flag, clamped result, ready still raised
        ref1_valid_pin <= 0;
        repeat (5) @(posedge aclk);
        fw(24'(rnd()));
        rd(OFF_STATUS, 32'h3, 32'h3);
        rd(OFF_RESULT, {8'h0, CLAMP_VALUE}, 32'hFFFFFF);
        // Calibration: good reference updates, lost reference flags aux only
        ref1_valid_pin <= 1;
        repeat (5) @(posedge aclk);
        wr(OFF_CAL_CMD, 32'h1);
        v = 24'(rnd());
        cq.push_back({SDC_CAL_PRIMARY, v});
        fw(v);
        wr(OFF_CAL_CMD, 32'h2);
        ref1_valid_pin <= 0;
        repeat (5) @(posedge aclk);
        fw(24'(rnd()));
        rd(OFF_STATUS, 32'h0A, 32'h0E);
        cmp(32'(cq.size()), 32'h0, 32'hFFFFFFFF);
        // Unmapped offset: error response, reads as zero
        ref1_valid_pin <= 1;
        wr(8'h40, 32'h5A);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR}, 32'h3);
        rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        results();
    end
endmodule // sdc_ctrl_tb_top

bind sdc_ctrl sdc_ctrl_assertions sdc_ctrl_assertions_inst (.aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid,
    .s_wready, .s_bvalid, .s_rdata, .s_rvalid, .s_rready, .ref1_valid_pin, .filter_word_valid, .cfg, .cal_write);
